// [logic/ics_top.sv]
`timescale 1ns/1ps
`include "ics_regs.svh"
module ics_top #(
  parameter int CW = 12
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          start,
  input  wire logic          low_gain,
  input  wire logic          dump_mode,
  input  wire logic [CW-1:0] n_lines,
  input  wire logic [CW-1:0] n_pixels,
  output logic      [3:0]    image_phase,
  output logic               reg_phase1,
  output logic               reg_phase2,
  output logic               reg_phase3,
  output logic               summing_well_gate,
  output logic               output_gate,
  output logic               reset_clock,
  output logic               dump_gate,
  output logic               busy,
  output logic               pixel_strobe
);
  typedef struct packed {
    ics_pkg::ics_state_t st;
    logic [11:0]         cnt;
    logic [3:0]          step;
    logic [CW-1:0]       line;
    logic [CW-1:0]       pix;
    logic                run;
    logic                lg;
    logic [3:0]          img;
    logic                r1;
    logic                r2;
    logic                r3;
    logic                sw;
    logic                og;
    logic                rx;
    logic                dg;
    logic                bsy;
    logic                pstb;
    logic [11:0]         since_r;
    logic [11:0]         since_ifall;
    logic [11:0]         since_iedge;
    logic [11:0]         since_dg;
    logic [11:0]         line_len;
  } ics_top_st_t;

  ics_top_st_t s;
  ics_top_st_t next_s;
  ics_ser_if   ser ();

  function automatic logic [3:0] ics_pat(input logic [3:0] step);
    case (step)
      4'h1:    return 4'he;
      4'h2:    return 4'hc;
      4'h3:    return 4'hd;
      4'h4:    return 4'h9;
      4'h5:    return 4'hb;
      4'h6:    return 4'h3;
      4'h7:    return 4'h7;
      default: return `ICS_COLLECT_PAT;
    endcase
  endfunction

  function automatic logic [11:0] ics_inc(input logic [11:0] v, input logic z);
    return z ? 12'h000 : ((v == 12'hfff) ? v : v + 12'h001);
  endfunction

  function automatic logic ics_last(input logic [CW-1:0] v,
                                    input logic [CW-1:0] n);
    return (n == '0) || (v == n - CW'(1));
  endfunction

  assign ser.ce       = ce;
  assign ser.run      = s.run;
  assign ser.low_gain = s.lg;
  assign ser.last     = ics_last(s.pix, n_pixels);

  ics_serial u_serial (
    .clk   (clk),
    .rst_n (rst_n),
    .ser   (ser.gen)
  );

  always_comb begin
    logic line_end;
    line_end = 1'b0;
    next_s = s;
    if (ce) begin
      next_s.pstb = 1'b0;
      if (s.cnt != 12'h000) begin
        next_s.cnt = s.cnt - 12'h001;
      end
      case (s.st)
        ics_pkg::ST_COLLECT: begin
          // A serial tail still running counts as busy
          if (start && !s.bsy) begin
            next_s.line = '0;
            next_s.lg   = low_gain;
            next_s.st   = ics_pkg::ST_PRE;
            next_s.cnt  = 12'(`ICS_DRT_CYC - 1);  // [R06]
          end
        end
        ics_pkg::ST_PRE: begin
          if (s.cnt == 12'h000) begin
            next_s.st   = ics_pkg::ST_LINE;
            next_s.step = 4'h1;
            next_s.cnt  = 12'(`ICS_TOI_CYC - 1);  // [R05]
          end
        end
        ics_pkg::ST_LINE: begin
          if (s.cnt == 12'h000) begin
            if (s.step == 4'(`ICS_LAST_STEP)) begin
              next_s.st  = ics_pkg::ST_POST;
              next_s.cnt = dump_mode ? 12'(`ICS_DRG_CYC - 1)   // [R08]
                                     : 12'(`ICS_DTR_CYC - 1);  // [R07]
            end else begin
              next_s.step = s.step + 4'h1;
              next_s.cnt  = 12'(`ICS_TOI_CYC - 1);  // [R05] [R04]
            end
          end
        end
        ics_pkg::ST_POST: begin
          next_s.step = 4'h0;
          if (s.cnt == 12'h000) begin
            if (dump_mode) begin
              next_s.st  = ics_pkg::ST_DUMP;
              next_s.cnt = 12'(`ICS_DGW_CYC - 1);
            end else begin
              next_s.st  = ics_pkg::ST_READ;
              next_s.pix = '0;
              next_s.run = 1'b1;
            end
          end
        end
        ics_pkg::ST_READ: begin
          if (ser.pix_done) begin
            next_s.pstb = 1'b1;
            next_s.pix  = s.pix + CW'(1);
            if (ics_last(s.pix, n_pixels)) begin
              next_s.run = 1'b0;
              line_end   = 1'b1;
            end
          end
        end
        ics_pkg::ST_DUMP: begin
          if (s.cnt == 12'h000) begin
            next_s.st  = ics_pkg::ST_DGR;
            next_s.cnt = 12'(`ICS_DGR_CYC - 1);  // [R09]
          end
        end
        ics_pkg::ST_DGR: begin
          line_end = (s.cnt == 12'h000);
        end
        default: begin
          next_s.st = ics_pkg::ST_COLLECT;
        end
      endcase
      if (line_end) begin
        next_s.line = s.line + CW'(1);
        if (ics_last(s.line, n_lines)) begin
          next_s.st = ics_pkg::ST_COLLECT;
        end else begin
          next_s.st  = ics_pkg::ST_PRE;
          next_s.cnt = 12'(`ICS_DRT_CYC - 1);  // [R06]
        end
      end
      // Pins follow the next state so they line up with it
      next_s.img = ics_pat(next_s.step);  // [R03] [R05]
      next_s.r1  = (next_s.st == ics_pkg::ST_LINE) || ser.r1;  // [R16]
      next_s.r2  = (next_s.st == ics_pkg::ST_LINE) || ser.r2;  // [R16]
      next_s.r3  = ser.r3;
      next_s.sw  = ser.sw;  // [R15]
      next_s.og  = next_s.lg;  // [R01]
      next_s.rx  = ser.rclk;
      next_s.dg  = (next_s.st == ics_pkg::ST_DUMP);  // [R08]
      next_s.bsy = (next_s.st != ics_pkg::ST_COLLECT) || ser.busy;
      next_s.since_r = ics_inc(s.since_r, next_s.r1 | next_s.r2 | next_s.r3);
      next_s.since_ifall = ics_inc(s.since_ifall, |(s.img & ~next_s.img));
      next_s.since_iedge = ics_inc(s.since_iedge, s.img != next_s.img);
      next_s.since_dg = ics_inc(s.since_dg, next_s.dg);
      next_s.line_len = ics_inc(s.line_len, next_s.st == ics_pkg::ST_PRE);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s     <= '0;
      s.img <= `ICS_COLLECT_PAT;
    end else begin
      s <= next_s;
    end
  end

  assign image_phase       = s.img;
  assign reg_phase1        = s.r1;
  assign reg_phase2        = s.r2;
  assign reg_phase3        = s.r3;
  assign summing_well_gate = s.sw;
  assign output_gate       = s.og;
  assign reset_clock       = s.rx;
  assign dump_gate         = s.dg;
  assign busy              = s.bsy;
  assign pixel_strobe      = s.pstb;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  collect_hold_a: assert property (
    (s.st == ics_pkg::ST_COLLECT) |-> image_phase[1] && image_phase[2]) // [R03]
    else $error("phases 2 and 3 not high while collecting");
  line_hold_a: assert property (
    (s.st == ics_pkg::ST_LINE) |-> reg_phase1 && reg_phase2) // [R16]
    else $error("register 1 and 2 not high during transfer");
  sw_follow_a: assert property (!output_gate |-> summing_well_gate == reg_phase3) // [R15]
    else $error("summing gate does not follow phase 3");
  lowgain_gate_a: assert property (output_gate |-> !summing_well_gate) // [R01]
    else $error("low gain gates wrong");
  line_len_a: assert property (
    $fell(s.st == ics_pkg::ST_LINE) |-> s.line_len >= 12'(`ICS_TI_MIN_CYC)) // [R04]
    else $error("line transfer too short");
  img_overlap_a: assert property (
    (image_phase != $past(image_phase)) |-> $past(s.since_iedge) >= 12'(`ICS_TOI_MIN_CYC)) // [R05]
    else $error("image edges too close");
  reg_to_img_a: assert property (
    $rose(image_phase[3]) |-> $past(s.since_r) >= 12'(`ICS_DRT_MIN_CYC)) // [R06]
    else $error("image rise too soon after register stop");
  img_to_reg_a: assert property (
    $rose(reg_phase3) |-> s.since_ifall >= 12'(`ICS_DTR_MIN_CYC)) // [R07]
    else $error("register restart too soon after image fall");
  dg_rise_a: assert property (
    $rose(dump_gate) |-> $past(s.since_r) >= 12'(`ICS_DRG_MIN_CYC)) // [R08]
    else $error("dump gate too soon after register fall");
  dg_to_reg_a: assert property (
    $rose(reg_phase1) |-> $past(s.since_dg) >= 12'(`ICS_DGR_MIN_CYC)) // [R09]
    else $error("register rise too soon after dump gate");
  ser_period_a: assert property (
    $rose(reg_phase3) && s.st == ics_pkg::ST_READ
      |=> !$rose(reg_phase3) [*5]) // [R10]
    else $error("serial period too short");
endmodule

// [logic/ics_regs.svh]
// Overview of operation
// [R01] Low-gain mode: output gate high, summing gate static
// [R02] Low-gain mode resets node before phase 2 falls
// [R03] Image phases 2 and 3 high while collecting
// [R04] Each line transfer lasts at least 65 us
// [R05] Image phase edges at least 7.5 us apart
// [R06] Register stop to image rise at least 5 us
// [R07] Image fall to register restart at least 7.5 us
// [R08] Dump gate rises 10 us after register fall
// [R09] Dump gate fall to register rise 7.5 us
// [R10] Serial clock period at least 300 ns
// [R11] Register phase edges overlap 0 to 5 percent
// [R12] Reset pulse width within 3 rise times, fifth period
// [R13] Reset falls 10 ns to 5 percent after phase
// [R14] Register phase 2 pulse kept short
// [R15] Summing gate follows phase 3 in normal readout
// [R16] Register phases 1, 2 high during line transfer
`ifndef ICS_REGS_SVH
`define ICS_REGS_SVH

`define ICS_CLK_NS      50
`define ICS_CYC_UP(t)   (((t) + `ICS_CLK_NS - 1) / `ICS_CLK_NS)
`define ICS_CYC_DN(t)   ((t) / `ICS_CLK_NS)

// Typical drive times
`define ICS_T_TOI_NS    10000
`define ICS_T_DRT_NS    10000
`define ICS_T_DTR_NS    10000
`define ICS_T_DRG_NS    10000
`define ICS_T_DGR_NS    10000
`define ICS_T_DGW_NS    10000
`define ICS_T_SER_NS    2000
`define ICS_T_RXW_NS    300
`define ICS_T_DX_NS     100
`define ICS_TOI_CYC     `ICS_CYC_UP(`ICS_T_TOI_NS)
`define ICS_DRT_CYC     `ICS_CYC_UP(`ICS_T_DRT_NS)
`define ICS_DTR_CYC     `ICS_CYC_UP(`ICS_T_DTR_NS)
`define ICS_DRG_CYC     `ICS_CYC_UP(`ICS_T_DRG_NS)
`define ICS_DGR_CYC     `ICS_CYC_UP(`ICS_T_DGR_NS)
`define ICS_DGW_CYC     `ICS_CYC_UP(`ICS_T_DGW_NS)
`define ICS_SER_CYC     `ICS_CYC_UP(`ICS_T_SER_NS)
`define ICS_RXW_CYC     `ICS_CYC_DN(`ICS_T_RXW_NS)
`define ICS_DX_CYC      `ICS_CYC_UP(`ICS_T_DX_NS)

// Least times checked at the pins
`define ICS_T_TI_MIN_NS  65000
`define ICS_T_TOI_MIN_NS 7500
`define ICS_T_DRT_MIN_NS 5000
`define ICS_T_DTR_MIN_NS 7500
`define ICS_T_DRG_MIN_NS 10000
`define ICS_T_DGR_MIN_NS 7500
`define ICS_T_SER_MIN_NS 300
`define ICS_TI_MIN_CYC   `ICS_CYC_UP(`ICS_T_TI_MIN_NS)
`define ICS_TOI_MIN_CYC  `ICS_CYC_UP(`ICS_T_TOI_MIN_NS)
`define ICS_DRT_MIN_CYC  `ICS_CYC_UP(`ICS_T_DRT_MIN_NS)
`define ICS_DTR_MIN_CYC  `ICS_CYC_UP(`ICS_T_DTR_MIN_NS)
`define ICS_DRG_MIN_CYC  `ICS_CYC_UP(`ICS_T_DRG_MIN_NS)
`define ICS_DGR_MIN_CYC  `ICS_CYC_UP(`ICS_T_DGR_MIN_NS)
`define ICS_SER_MIN_CYC  `ICS_CYC_UP(`ICS_T_SER_MIN_NS)

// Serial cycle slots, in clocks from pixel start; last line transfer step and collect image pattern
`define ICS_R1_END      16
`define ICS_R2_BEG      15
`define ICS_R2_END      22
`define ICS_R3_BEG      21
`define ICS_LAST_STEP   8
`define ICS_COLLECT_PAT 4'h6

`endif

// [logic/ics_pkg.sv]
package ics_pkg;
  typedef enum logic [2:0] {
    ST_COLLECT, ST_PRE, ST_LINE, ST_POST, ST_READ, ST_DUMP, ST_DGR
  } ics_state_t;
endpackage

// [logic/ics_ser_if.sv]
`timescale 1ns/1ps
interface ics_ser_if;
  logic ce;
  logic run;
  logic last;
  logic low_gain;
  logic busy;
  logic pix_done;
  logic r1;
  logic r2;
  logic r3;
  logic sw;
  logic rclk;
  modport ctrl (output ce, run, last, low_gain,
                input busy, pix_done, r1, r2, r3, sw, rclk);
  modport gen  (input ce, run, last, low_gain,
                output busy, pix_done, r1, r2, r3, sw, rclk);
endinterface

// [logic/ics_serial.sv]
`timescale 1ns/1ps
`include "ics_regs.svh"
module ics_serial (
  input wire logic clk,
  input wire logic rst_n,
  ics_ser_if.gen   ser
);
  localparam logic [5:0] P   = 6'(`ICS_SER_CYC);
  localparam logic [5:0] RXW = 6'(`ICS_RXW_CYC);
  localparam logic [5:0] DX  = 6'(`ICS_DX_CYC);
  // Head and tail wrap whole normal-mode reset pulses around a line's burst
  localparam logic [5:0] HS  = P + 6'h01 + DX - RXW;

  typedef struct packed {
    logic       busy;
    logic       head;
    logic       tail;
    logic [5:0] c;
  } ics_ser_st_t;

  ics_ser_st_t s;
  ics_ser_st_t next_s;

  function automatic logic ics_win(input logic [5:0] c,
                                   input logic [5:0] beg,
                                   input logic [5:0] len);
    logic [5:0] d;
    d = (c >= beg) ? 6'(c - beg) : 6'(c + P - beg);
    return d < len;
  endfunction

  always_comb begin
    next_s = s;
    if (ser.ce) begin
      if (!s.busy) begin
        if (ser.run) begin
          next_s.busy = 1'b1;
          next_s.head = 1'b1;
          next_s.c    = HS;
        end
      end else if (s.tail) begin
        if (s.c == DX) begin
          next_s.busy = 1'b0;
          next_s.tail = 1'b0;
          next_s.c    = 6'h00;
        end else begin
          next_s.c = s.c + 6'h01;
        end
      end else if (s.c == P - 6'h01) begin
        next_s.c    = 6'h00;
        next_s.head = 1'b0;
        if (!s.head && (!ser.run || ser.last)) begin
          next_s.tail = 1'b1;
        end
      end else begin
        next_s.c = s.c + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ser.busy     = s.busy;
  assign ser.pix_done = s.busy && !s.head && !s.tail && (s.c == P - 6'h01);
  // Phase 2 short, phases 1 and 3 long, one clock of overlap
  assign ser.r1 = s.busy && !s.tail
                         && (s.c < 6'(`ICS_R1_END));  // [R14] [R11]
  assign ser.r2 = s.busy && !s.tail && (s.c >= 6'(`ICS_R2_BEG))
                         && (s.c < 6'(`ICS_R2_END));  // [R14] [R11]
  assign ser.r3 = s.busy && (s.c >= 6'(`ICS_R3_BEG) || s.c == 6'h00);
  assign ser.sw = ser.low_gain ? 1'b0 : ser.r3;  // [R15] [R01]
  // Normal: reset ends DX after phase 3 falls; low gain: after phase 1,
  // well before phase 2 falls and dumps charge into the node
  assign ser.rclk = s.busy && (ser.low_gain
      ? ics_win(s.c, 6'(`ICS_R1_END) + DX - RXW, RXW)       // [R02]
      : ics_win(s.c, P + 6'h01 + DX - RXW, RXW));           // [R12] [R13]

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ser.ce);

  sequence ics_r2_pulse;
    ser.r2 [*7] ##1 !ser.r2;
  endsequence
  sequence ics_rx_pulse;
    ser.rclk [*6] ##1 !ser.rclk;
  endsequence

  r2_short_a: assert property ($rose(ser.r2) |-> ics_r2_pulse) // [R14]
    else $error("phase 2 pulse width wrong");
  reg_overlap_a: assert property ($rose(ser.r2) |-> ser.r1 ##1 !ser.r1) // [R11]
    else $error("phase 1 to 2 overlap wrong");
  rst_width_a: assert property ($rose(ser.rclk) |-> ics_rx_pulse) // [R12]
    else $error("reset pulse width wrong");
  rst_delay_a: assert property (
    (!ser.low_gain && $fell(ser.r3) && ser.busy)
      |-> ser.rclk ##1 ser.rclk ##1 !ser.rclk) // [R13]
    else $error("reset fall not 2 clocks after phase 3");
  lowgain_seq_a: assert property (
    (ser.low_gain && $fell(ser.r1)) |-> ##2 !ser.rclk ##4 $fell(ser.r2)) // [R02]
    else $error("low gain reset not ahead of phase 2 fall");
endmodule

// [testbench/ics_sensor_model.sv]
`timescale 1ns/1ps
module ics_sensor_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        busy,
  input  wire logic [3:0]  image_phase,
  input  wire logic        reg_phase1,
  input  wire logic        reg_phase2,
  input  wire logic        reg_phase3,
  input  wire logic        summing_well_gate,
  input  wire logic        output_gate,
  input  wire logic        reset_clock,
  input  wire logic        dump_gate,
  output logic      [15:0] viol,
  output logic      [15:0] pixels,
  output logic      [15:0] lines,
  output logic      [15:0] dumps
);
  // Least gaps in 50 ns clocks
  localparam int TI_MIN  = 1300;
  localparam int TOI_MIN = 150;
  localparam int DRT_MIN = 100;
  localparam int DTR_MIN = 150;
  localparam int DRG_MIN = 200;
  localparam int DGR_MIN = 150;
  localparam int SER_MIN = 6;
  // Limits for a 40 clock serial period
  localparam int OV_MAX  = 2;
  localparam int RW_MAX  = 8;
  localparam int DX_MAX  = 1;
  localparam int W2_MAX  = 10;
  logic [3:0]  p_img;
  logic [2:0]  p_reg;
  logic        p_rst;
  logic        p_dg;
  logic        first;
  logic [15:0] t_img, t_line, t_reg, t_rf, t_dg, t_r1, t_xf, ov, rw, w2;

  function automatic logic [15:0] sat(input logic [15:0] x);
    return (x == 16'hffff) ? x : x + 16'h0001;
  endfunction

  always_ff @(posedge clk) begin
    int         v;
    logic [2:0] rg;
    logic [2:0] rise;
    logic [2:0] fall;
    logic       ser;
    logic       ovl;
    rg   = {reg_phase3, reg_phase2, reg_phase1};
    rise = rg & ~p_reg;
    fall = p_reg & ~rg;
    ser  = (t_r1 < 16'h0030) && (image_phase == 4'h6);
    ovl  = $countones(rg) > 1;
    v    = 0;
    if (!rst_n) begin
      {t_img, t_line, t_reg, t_rf, t_dg, t_r1, t_xf} <= '1;
      {ov, rw, w2, viol, pixels, lines, dumps} <= '0;
      {p_img, p_reg, p_rst, p_dg, first} <= {4'h6, 6'h01};
    end else if (ce) begin
      if (!busy && image_phase !== 4'h6) v++;
      if (image_phase != 4'h6 && !(reg_phase1 && reg_phase2)) v++;
      if (image_phase != p_img) begin
        if (p_img != 4'h6 && t_img < TOI_MIN) v++;
        if (p_img == 4'h6 && t_reg < DRT_MIN) v++;
        if (image_phase == 4'h6 && t_line < TI_MIN) v++;
      end
      if (rise != 0 && image_phase == 4'h6 && t_img < DTR_MIN) v++;
      // t_rf reads one less than the clocks since the fall
      if (dump_gate && !p_dg && t_rf + 1 < DRG_MIN) v++;
      if (rise != 0 && t_dg < DGR_MIN) v++;
      if (rise[0] && t_r1 < SER_MIN) v++;
      if (ser && ovl && ov >= OV_MAX) v++;
      if (reset_clock && rw >= RW_MAX) v++;
      if (p_rst && !reset_clock && !first &&
          (fall != 0 || t_rf > DX_MAX)) v++;
      if (ser && reg_phase2 && w2 >= W2_MAX) v++;
      if (!output_gate && summing_well_gate !== reg_phase3) v++;
      if (output_gate && summing_well_gate) v++;
      if (output_gate && fall[1] && ser &&
          (reset_clock || t_xf > RW_MAX)) v++;
      if (image_phase == 4'h6 && p_img != 4'h6) begin
        lines <= lines + 16'h0001;
        first <= 1'b1;
      end else if (p_rst && !reset_clock) begin
        first <= 1'b0;
      end
      if (fall[1] && ser) pixels <= pixels + 16'h0001;
      if (dump_gate && !p_dg) dumps <= dumps + 16'h0001;
      viol   <= viol + 16'(v);
      t_img  <= (image_phase != p_img) ? 16'h0000 : sat(t_img);
      t_line <= (p_img == 4'h6 && image_phase != 4'h6) ? 16'h0000
                                                        : sat(t_line);
      t_reg  <= (rg != p_reg) ? 16'h0000 : sat(t_reg);
      t_rf   <= (fall != 0) ? 16'h0000 : sat(t_rf);
      t_r1   <= rise[0] ? 16'h0000 : sat(t_r1);
      t_dg   <= (p_dg && !dump_gate) ? 16'h0000 : sat(t_dg);
      t_xf   <= (p_rst && !reset_clock) ? 16'h0000 : sat(t_xf);
      ov     <= ovl ? sat(ov) : 16'h0000;
      rw     <= reset_clock ? sat(rw) : 16'h0000;
      w2     <= reg_phase2 ? sat(w2) : 16'h0000;
      {p_img, p_reg, p_rst, p_dg} <= {image_phase, rg, reset_clock, dump_gate};
    end
  end
endmodule

// [testbench/test_imager_clock_sequencer.sv]
`timescale 1ns/1ps
module test_imager_clock_sequencer;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        start = 1'b0;
  logic        low_gain = 1'b0;
  logic        dump_mode = 1'b0;
  logic [11:0] n_lines = 12'h0001;
  logic [11:0] n_pixels = 12'h0001;
  logic [3:0]  image_phase;
  logic        r1, r2, r3, sw, og, rc, dg, busy, pixel_strobe;
  logic [15:0] viol, pixels, lines, dumps;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          strobes = 0;

  always #25 clk = ~clk;
  always @(posedge clk) if (pixel_strobe === 1'b1) strobes++;

  ics_top #(.CW(12)) u_ics_top (
    .clk(clk), .rst_n(rst_n), .ce(ce), .start(start),
    .low_gain(low_gain), .dump_mode(dump_mode), .n_lines(n_lines),
    .n_pixels(n_pixels), .image_phase(image_phase), .reg_phase1(r1),
    .reg_phase2(r2), .reg_phase3(r3), .summing_well_gate(sw),
    .output_gate(og), .reset_clock(rc), .dump_gate(dg), .busy(busy),
    .pixel_strobe(pixel_strobe));

  ics_sensor_model u_ics_sensor_model (
    .clk(clk), .rst_n(rst_n), .ce(ce), .busy(busy),
    .image_phase(image_phase), .reg_phase1(r1), .reg_phase2(r2),
    .reg_phase3(r3), .summing_well_gate(sw), .output_gate(og),
    .reset_clock(rc), .dump_gate(dg), .viol(viol), .pixels(pixels),
    .lines(lines), .dumps(dumps));

  task automatic check(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One frame; poke retries start mid-frame and freezes the clock enable
  task automatic frame(input logic lg, dm, poke, input logic [11:0] nl, np);
    logic [15:0] p0, l0, d0, v0, el, ep;
    logic [3:0]  ph;
    int          k;
    p0 = pixels;
    l0 = lines;
    d0 = dumps;
    v0 = viol;
    strobes = 0;
    el = (nl == 12'h000) ? 16'h0001 : 16'(nl);
    ep = dm ? 16'h0000 : el * ((np == 12'h000) ? 16'h0001 : 16'(np));
    low_gain <= lg;
    dump_mode <= dm;
    n_lines <= nl;
    n_pixels <= np;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    check("busy", 16'(busy), 16'h0001);
    if (poke) begin
      repeat (300) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      ce <= 1'b0;
      @(posedge clk);
      ph = image_phase;
      // Longer than one image step, so a missed freeze shows
      repeat (220) @(posedge clk);
      check("frozen image", 16'(image_phase), 16'(ph));
      ce <= 1'b1;
    end
    for (k = 0; k < 20000 && busy !== 1'b0; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    check("busy end", 16'(busy), 16'h0000);
    check("lines", lines - l0, el);
    check("pixels", pixels - p0, ep);
    check("strobes", 16'(strobes), ep);
    check("dumps", dumps - d0, dm ? el : 16'h0000);
    check("violations", viol - v0, 16'h0000);
    check("idle image", 16'(image_phase), 16'h0006);
  endtask

  task automatic t_reset;
    check("image", 16'(image_phase), 16'h0006);
    check("pins", 16'({r1, r2, r3, sw, og, rc, dg, busy}), 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_normal;
    frame(1'b0, 1'b0, 1'b0, 12'h002, 12'h003);
    check("output gate", 16'(og), 16'h0000);
    $display("test normal done");
  endtask

  task automatic t_low_gain;
    frame(1'b1, 1'b0, 1'b0, 12'h001, 12'h002);
    check("output gate", 16'(og), 16'h0001);
    $display("test low gain done");
  endtask

  task automatic t_dump;
    frame(1'b0, 1'b1, 1'b0, 12'h002, 12'h002);
    $display("test dump done");
  endtask

  task automatic t_refuse;
    frame(1'b0, 1'b0, 1'b1, 12'h000, 12'h000);
    $display("test refuse done");
  endtask

  initial begin
    #(50 * 60000);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    t_reset();
    rst_n <= 1'b1;
    @(posedge clk);
    t_normal();
    t_low_gain();
    t_dump();
    t_refuse();
    print_verdict();
  end
endmodule
